// ===== hw/mecc_ctrl.sv
// memory ecc controller: encoder, decoder, indirect access, init, logging
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps

// Summary of operation
// - correction disabled after reset until enabled
// - disabled: raw store, raw read back
// - correct single flips, only flag doubles
// - five check bits for byte lanes
// - writes encoded, reads decoded on path
// - eight lanes of 8+5, 104 bits
// - partial writes read, check, merge, rewrite; a peripheral one with a double error is acked without rewrite
// - other memories' codeword sizes kept as constants
// - initializer clears data and check bits
// - table logs single-error addresses when enabled
// - separate single and double error interrupts
// - register port reaches memory via mux
// - check fields packed four per word
// - byte n at bits 8n+7:8n
// - single-error counter readable by software
// - stalled indirect access times out
// - current single/double error addresses readable
// - software can force both interrupts
// - data and check bits overwritten separately
// - timeout fixed at 2048 register clocks
// - initialization runs to completion uninterrupted
module mecc_ctrl (
    input wire logic pclk, // register and memory clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic init_req, // memory clear request pulse from reset control
    input wire logic per_req, // peripheral request, held until ack
    input wire logic per_we, // peripheral write
    input wire logic [7:0] per_be, // peripheral byte enables
    input wire logic [mecc_pkg::ADDR_W-1:0] per_addr, // peripheral word address
    input wire logic [mecc_pkg::DATA_W-1:0] per_wdata, // peripheral write data
    output logic per_ack, // peripheral access done pulse
    output logic [mecc_pkg::DATA_W-1:0] per_rdata, // corrected read data
    output logic per_sbe, // single error seen on this access
    output logic per_dbe, // double error seen on this access
    output logic mem_req, // memory request, held until ack or indirect access timeout
    output logic mem_we, // memory write
    output logic [mecc_pkg::ADDR_W-1:0] mem_addr, // memory word address
    output logic [mecc_pkg::WORD_W-1:0] mem_wdata, // check bits over data
    input wire logic mem_ack, // memory done pulse
    input wire logic [mecc_pkg::WORD_W-1:0] mem_rdata, // valid with mem_ack on reads
    output logic irq_sbe, // single error interrupt, level
    output logic irq_dbe // double error interrupt, level
);
    typedef struct packed {
        mecc_pkg::mecc_state_t st;
        mecc_pkg::mecc_src_t src;
        logic ecc_en;
        logic lut_en;
        logic frc_sbe;
        logic frc_dbe;
        logic init_pend;
        logic init_busy;
        logic init_done;
        logic sbe_flag;
        logic dbe_flag;
        logic tmo_flag;
        logic acc_busy;
        logic acc_wr;
        logic acc_dovr;
        logic acc_eovr;
        logic [mecc_pkg::ADDR_W-1:0] acc_addr;
        logic [mecc_pkg::DATA_W-1:0] wdata;
        logic [63:0] wecc_pk;
        logic [mecc_pkg::DATA_W-1:0] rdata;
        logic [mecc_pkg::CHK_W-1:0] recc;
        logic [mecc_pkg::ADDR_W-1:0] sbe_addr;
        logic [mecc_pkg::ADDR_W-1:0] dbe_addr;
        logic [mecc_pkg::CNT_W-1:0] sbe_cnt;
        logic [mecc_pkg::LUT_N-1:0][mecc_pkg::ADDR_W-1:0] lut;
        logic [1:0] lut_ptr;
        logic [11:0] wdog;
        logic [mecc_pkg::ADDR_W-1:0] init_addr;
        logic cur_we;
        logic [7:0] cur_be;
        logic [mecc_pkg::DATA_W-1:0] cur_wdata;
        logic mem_req;
        logic mem_we;
        logic [mecc_pkg::ADDR_W-1:0] mem_addr;
        logic [mecc_pkg::WORD_W-1:0] mem_wdata;
        logic per_ack;
        logic [mecc_pkg::DATA_W-1:0] per_rdata;
        logic per_sbe;
        logic per_dbe;
        logic [31:0] prdata;
        logic pslverr;
    } mecc_regs_t;

    mecc_regs_t q;
    mecc_regs_t d;

    // five check bits per lane: four hamming bits and overall parity
    function automatic logic [4:0] lane_enc(input logic [7:0] x);
        logic [3:0] c;
        c[0] = x[0] ^ x[1] ^ x[3] ^ x[4] ^ x[6];
        c[1] = x[0] ^ x[2] ^ x[3] ^ x[5] ^ x[6];
        c[2] = x[1] ^ x[2] ^ x[3] ^ x[7];
        c[3] = ^x[7:4];
        return {(^x) ^ (^c), c};
    endfunction

    // decode one lane: {sbe, dbe, corrected byte}
    function automatic logic [9:0] lane_dec(input logic [7:0] x, input logic [4:0] c);
        logic [12:1] cw;
        logic [3:0] s;
        logic p;
        logic one;
        logic two;
        cw = {x[7], x[6], x[5], x[4], c[3], x[3], x[2], x[1], c[2], x[0], c[1], c[0]};
        s = 4'h0;
        for (int i = 1; i <= 12; i++) begin
            if (cw[i]) begin
                s = s ^ 4'(i);
            end
        end
        p = (^cw) ^ c[4];
        one = p && (s <= 4'hC);
        two = (!p && (s != 4'h0)) || (p && (s > 4'hC));
        if (one && (s != 4'h0)) begin
            cw[s] = ~cw[s];
        end
        return {one, two, cw[12:9], cw[7:5], cw[3]};
    endfunction

    logic [mecc_pkg::DATA_W-1:0] dec_data;
    logic [7:0] lane_sbe;
    logic [7:0] lane_dbe;
    logic [mecc_pkg::DATA_W-1:0] merged;
    logic [mecc_pkg::DATA_W-1:0] enc_in;
    logic [mecc_pkg::CHK_W-1:0] enc_chk;
    logic [mecc_pkg::CHK_W-1:0] wecc;
    logic [63:0] recc_pk;
    logic word_sbe;
    logic word_dbe;

    // per-lane decode, merge, encode and check-field packing
    genvar g;
    generate
        for (g = 0; g < mecc_pkg::LANES; g++) begin : g_lane
            logic [9:0] r;
            assign r = lane_dec(mem_rdata[g*8 +: 8], mem_rdata[mecc_pkg::DATA_W + g*5 +: 5]);
            assign lane_sbe[g] = r[9];
            assign lane_dbe[g] = r[8];
            assign dec_data[g*8 +: 8] = q.ecc_en ? r[7:0] : mem_rdata[g*8 +: 8];
            assign merged[g*8 +: 8] = (q.src == mecc_pkg::SRC_IND) ?
                (q.acc_dovr ? q.wdata[g*8 +: 8] : dec_data[g*8 +: 8]) :
                (q.cur_be[g] ? q.cur_wdata[g*8 +: 8] : dec_data[g*8 +: 8]);
            assign enc_chk[g*5 +: 5] = lane_enc(enc_in[g*8 +: 8]);
            assign wecc[g*5 +: 5] = q.wecc_pk[g*8 +: 5];
            assign recc_pk[g*8 +: 8] = {3'h0, q.recc[g*5 +: 5]};
        end
    endgenerate

    assign enc_in = (q.st == mecc_pkg::ST_IDLE) ? per_wdata : merged;
    assign word_dbe = q.ecc_en && (|lane_dbe);
    assign word_sbe = q.ecc_en && (|lane_sbe) && !word_dbe;

    // apb setup-cycle register read mux
    function automatic logic [31:0] reg_rd(input mecc_regs_t s, input logic [7:0] a, input logic [63:0] rp);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            mecc_pkg::OFS_CTRL: begin
                v[mecc_pkg::CTRL_ECC_EN] = s.ecc_en;
                v[mecc_pkg::CTRL_LUT_EN] = s.lut_en;
                v[mecc_pkg::CTRL_FRC_SBE] = s.frc_sbe;
                v[mecc_pkg::CTRL_FRC_DBE] = s.frc_dbe;
            end
            mecc_pkg::OFS_STAT: begin
                v[mecc_pkg::STAT_INIT_BUSY] = s.init_busy | s.init_pend;
                v[mecc_pkg::STAT_INIT_DONE] = s.init_done;
                v[mecc_pkg::STAT_SBE] = s.sbe_flag;
                v[mecc_pkg::STAT_DBE] = s.dbe_flag;
                v[mecc_pkg::STAT_ACC_BUSY] = s.acc_busy;
                v[mecc_pkg::STAT_TMO] = s.tmo_flag;
            end
            mecc_pkg::OFS_SBE_ADDR: v[mecc_pkg::ADDR_W-1:0] = s.sbe_addr;
            mecc_pkg::OFS_DBE_ADDR: v[mecc_pkg::ADDR_W-1:0] = s.dbe_addr;
            mecc_pkg::OFS_SBE_CNT: v[mecc_pkg::CNT_W-1:0] = s.sbe_cnt;
            mecc_pkg::OFS_ACC_ADDR: v[mecc_pkg::ADDR_W-1:0] = s.acc_addr;
            mecc_pkg::OFS_ACC_CTRL: v[2:0] = {s.acc_eovr, s.acc_dovr, s.acc_wr};
            mecc_pkg::OFS_ACC_START: v[0] = s.acc_busy;
            mecc_pkg::OFS_WDATA0: v = s.wdata[31:0];
            mecc_pkg::OFS_WDATA1: v = s.wdata[63:32];
            mecc_pkg::OFS_WECC0: v = s.wecc_pk[31:0];
            mecc_pkg::OFS_WECC1: v = s.wecc_pk[63:32];
            mecc_pkg::OFS_RDATA0: v = s.rdata[31:0];
            mecc_pkg::OFS_RDATA1: v = s.rdata[63:32];
            mecc_pkg::OFS_RECC0: v = rp[31:0];
            mecc_pkg::OFS_RECC1: v = rp[63:32];
            8'h40, 8'h44, 8'h48, 8'h4C: v[mecc_pkg::ADDR_W-1:0] = s.lut[a[3:2]];
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= 8'h4C);
    endfunction

    // next-state logic
    always_comb begin
        d = q;
        d.per_ack = 1'b0;
        d.per_sbe = 1'b0;
        d.per_dbe = 1'b0;
        // apb setup: latch read data and error answer
        if (psel && !penable) begin
            d.prdata = reg_rd(q, paddr, recc_pk);
            d.pslverr = !reg_hit(paddr);
        end
        // apb access: writes take effect here
        if (psel && penable && pwrite) begin
            case (paddr)
                mecc_pkg::OFS_CTRL: begin
                    d.ecc_en = pwdata[mecc_pkg::CTRL_ECC_EN];
                    d.lut_en = pwdata[mecc_pkg::CTRL_LUT_EN];
                    d.frc_sbe = pwdata[mecc_pkg::CTRL_FRC_SBE];
                    d.frc_dbe = pwdata[mecc_pkg::CTRL_FRC_DBE];
                    if (pwdata[mecc_pkg::CTRL_INIT]) begin
                        d.init_pend = 1'b1;
                    end
                end
                mecc_pkg::OFS_STAT: begin
                    // write one clears; hardware sets below win
                    if (pwdata[mecc_pkg::STAT_SBE]) begin
                        d.sbe_flag = 1'b0;
                    end
                    if (pwdata[mecc_pkg::STAT_DBE]) begin
                        d.dbe_flag = 1'b0;
                    end
                    if (pwdata[mecc_pkg::STAT_TMO]) begin
                        d.tmo_flag = 1'b0;
                    end
                end
                mecc_pkg::OFS_ACC_ADDR: d.acc_addr = pwdata[mecc_pkg::ADDR_W-1:0];
                mecc_pkg::OFS_ACC_CTRL: begin
                    d.acc_wr = pwdata[mecc_pkg::ACC_WR];
                    d.acc_dovr = pwdata[mecc_pkg::ACC_DOVR];
                    d.acc_eovr = pwdata[mecc_pkg::ACC_EOVR];
                end
                mecc_pkg::OFS_ACC_START: begin
                    if (pwdata[0]) begin
                        d.acc_busy = 1'b1;
                    end
                end
                mecc_pkg::OFS_WDATA0: d.wdata[31:0] = pwdata;
                mecc_pkg::OFS_WDATA1: d.wdata[63:32] = pwdata;
                mecc_pkg::OFS_WECC0: d.wecc_pk[31:0] = pwdata & mecc_pkg::ECC_FIELD_MASK;
                mecc_pkg::OFS_WECC1: d.wecc_pk[63:32] = pwdata & mecc_pkg::ECC_FIELD_MASK;
                default: d.pslverr = q.pslverr;
            endcase
        end
        if (init_req) begin
            d.init_pend = 1'b1;
        end
        case (q.st)
            mecc_pkg::ST_IDLE: begin
                d.wdog = 12'h000;
                if (q.init_pend) begin
                    d.init_pend = 1'b0;
                    d.init_busy = 1'b1;
                    d.init_done = 1'b0;
                    d.src = mecc_pkg::SRC_INIT;
                    d.init_addr = '0;
                    d.mem_req = 1'b1;
                    d.mem_we = 1'b1;
                    d.mem_addr = '0;
                    d.mem_wdata = '0;
                    d.st = mecc_pkg::ST_INIT;
                end else if (q.acc_busy) begin
                    // indirect access takes the memory port
                    d.src = mecc_pkg::SRC_IND;
                    d.cur_we = q.acc_wr;
                    d.mem_req = 1'b1;
                    d.mem_we = 1'b0;
                    d.mem_addr = q.acc_addr;
                    d.st = mecc_pkg::ST_READ;
                end else if (per_req && !q.per_ack) begin
                    // a request still up in its ack cycle is the finished one, not a new one
                    d.src = mecc_pkg::SRC_PER;
                    d.cur_we = per_we;
                    d.cur_be = per_be;
                    d.cur_wdata = per_wdata;
                    d.mem_req = 1'b1;
                    d.mem_addr = per_addr;
                    if (per_we && (per_be == 8'hFF)) begin
                        d.mem_we = 1'b1;
                        d.mem_wdata = {q.ecc_en ? enc_chk : '0, per_wdata};
                        d.st = mecc_pkg::ST_WRITE;
                    end else begin
                        d.mem_we = 1'b0;
                        d.st = mecc_pkg::ST_READ;
                    end
                end
            end
            mecc_pkg::ST_READ: begin
                if (q.src == mecc_pkg::SRC_IND) begin
                    d.wdog = q.wdog + 12'h001;
                end
                if (mem_ack) begin
                    d.mem_req = 1'b0;
                    if (word_dbe) begin
                        d.dbe_flag = 1'b1;
                        d.dbe_addr = q.mem_addr;
                    end else if (word_sbe) begin
                        d.sbe_flag = 1'b1;
                        d.sbe_addr = q.mem_addr;
                        if (q.sbe_cnt != '1) begin
                            d.sbe_cnt = q.sbe_cnt + 1'b1;
                        end
                        if (q.lut_en) begin
                            d.lut[q.lut_ptr] = q.mem_addr;
                            d.lut_ptr = q.lut_ptr + 2'h1;
                        end
                    end
                    if (q.src == mecc_pkg::SRC_IND && !q.cur_we) begin
                        d.rdata = dec_data;
                        d.recc = mem_rdata[mecc_pkg::WORD_W-1:mecc_pkg::DATA_W];
                        d.acc_busy = 1'b0;
                        d.st = mecc_pkg::ST_IDLE;
                    end else if (q.src == mecc_pkg::SRC_PER && (!q.cur_we || word_dbe)) begin
                        d.per_rdata = dec_data;
                        d.per_ack = 1'b1;
                        d.per_sbe = word_sbe;
                        d.per_dbe = word_dbe;
                        d.st = mecc_pkg::ST_IDLE;
                    end else begin
                        // write back merged word; check bits recomputed only when ecc enabled and not overridden
                        d.mem_req = 1'b1;
                        d.mem_we = 1'b1;
                        d.per_sbe = word_sbe;
                        if (q.src == mecc_pkg::SRC_IND) begin
                            d.mem_wdata = {q.acc_eovr ? wecc :
                                (q.ecc_en ? enc_chk : mem_rdata[mecc_pkg::WORD_W-1:mecc_pkg::DATA_W]), merged};
                        end else begin
                            d.mem_wdata = {q.ecc_en ? enc_chk : '0, merged};
                        end
                        d.st = mecc_pkg::ST_WRITE;
                    end
                end else if (q.src == mecc_pkg::SRC_IND && q.wdog == mecc_pkg::WDOG_CYCLES - 12'h001) begin
                    d.mem_req = 1'b0;
                    d.tmo_flag = 1'b1;
                    d.acc_busy = 1'b0;
                    d.st = mecc_pkg::ST_IDLE;
                end
            end
            mecc_pkg::ST_WRITE: begin
                if (q.src == mecc_pkg::SRC_IND) begin
                    d.wdog = q.wdog + 12'h001;
                end
                if (mem_ack) begin
                    d.mem_req = 1'b0;
                    d.st = mecc_pkg::ST_IDLE;
                    if (q.src == mecc_pkg::SRC_IND) begin
                        d.acc_busy = 1'b0;
                    end else begin
                        d.per_ack = 1'b1;
                    end
                end else if (q.src == mecc_pkg::SRC_IND && q.wdog == mecc_pkg::WDOG_CYCLES - 12'h001) begin
                    d.mem_req = 1'b0;
                    d.tmo_flag = 1'b1;
                    d.acc_busy = 1'b0;
                    d.st = mecc_pkg::ST_IDLE;
                end
            end
            mecc_pkg::ST_INIT: begin
                // walk runs to the end, nothing stops it
                if (mem_ack) begin
                    if (q.init_addr == mecc_pkg::LAST_ADDR) begin
                        d.mem_req = 1'b0;
                        d.init_busy = 1'b0;
                        d.init_done = 1'b1;
                        d.st = mecc_pkg::ST_IDLE;
                    end else begin
                        d.init_addr = q.init_addr + 1'b1;
                        d.mem_addr = q.init_addr + 1'b1;
                    end
                end
            end
            default: d.st = mecc_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = q.pslverr;
    assign per_ack = q.per_ack;
    assign per_rdata = q.per_rdata;
    assign per_sbe = q.per_sbe;
    assign per_dbe = q.per_dbe;
    assign mem_req = q.mem_req;
    assign mem_we = q.mem_we;
    assign mem_addr = q.mem_addr;
    assign mem_wdata = q.mem_wdata;
    assign irq_sbe = q.sbe_flag | q.frc_sbe;
    assign irq_dbe = q.dbe_flag | q.frc_dbe;
endmodule

// ===== hw/mecc_pkg.sv
// constants and types shared by the memory ecc controller
package mecc_pkg;
    // geometry of the byte-writeable protected memory
    localparam int DATA_W = 64;
    localparam int LANES = 8;
    localparam int LANE_W = 8;
    localparam int LANE_CHK = 5;
    localparam int CHK_W = LANES * LANE_CHK;
    localparam int WORD_W = DATA_W + CHK_W;
    localparam int ADDR_W = 9;
    localparam int DEPTH = 512;
    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
    // check bits needed per data width band: 8, 16, 32, 64, 128, 256 bits
    localparam int CHK_FOR_8 = 5;
    localparam int CHK_FOR_16 = 6;
    localparam int CHK_FOR_32 = 7;
    localparam int CHK_FOR_64 = 8;
    localparam int CHK_FOR_128 = 9;
    localparam int CHK_FOR_256 = 10;
    // codeword lengths of the other protected memories
    localparam int RAM64_CW_W = 72;
    localparam int FIFO35_CW_W = 42;
    localparam int FIFO32_CW_W = 39;
    localparam int BUF16_CW_W = 22;
    // indirect access watchdog, in register clock cycles
    localparam logic [11:0] WDOG_CYCLES = 12'h800;
    localparam int CNT_W = 16;
    localparam int LUT_N = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_SBE_ADDR = 8'h08;
    localparam logic [7:0] OFS_DBE_ADDR = 8'h0C;
    localparam logic [7:0] OFS_SBE_CNT = 8'h10;
    localparam logic [7:0] OFS_ACC_ADDR = 8'h14;
    localparam logic [7:0] OFS_ACC_CTRL = 8'h18;
    localparam logic [7:0] OFS_ACC_START = 8'h1C;
    localparam logic [7:0] OFS_WDATA0 = 8'h20;
    localparam logic [7:0] OFS_WDATA1 = 8'h24;
    localparam logic [7:0] OFS_WECC0 = 8'h28;
    localparam logic [7:0] OFS_WECC1 = 8'h2C;
    localparam logic [7:0] OFS_RDATA0 = 8'h30;
    localparam logic [7:0] OFS_RDATA1 = 8'h34;
    localparam logic [7:0] OFS_RECC0 = 8'h38;
    localparam logic [7:0] OFS_RECC1 = 8'h3C;
    localparam logic [7:0] OFS_LUT0 = 8'h40;
    // field positions
    localparam int CTRL_ECC_EN = 0;
    localparam int CTRL_INIT = 1;
    localparam int CTRL_LUT_EN = 2;
    localparam int CTRL_FRC_SBE = 8;
    localparam int CTRL_FRC_DBE = 9;
    localparam int STAT_INIT_BUSY = 0;
    localparam int STAT_INIT_DONE = 1;
    localparam int STAT_SBE = 2;
    localparam int STAT_DBE = 3;
    localparam int STAT_ACC_BUSY = 4;
    localparam int STAT_TMO = 5;
    localparam int ACC_WR = 0;
    localparam int ACC_DOVR = 1;
    localparam int ACC_EOVR = 2;
    // packed check fields: five bits per byte of the register word
    localparam logic [31:0] ECC_FIELD_MASK = 32'h1F1F1F1F;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10,
        ST_INIT = 2'b11
    } mecc_state_t;
    typedef enum logic [1:0] {
        SRC_PER = 2'b00,
        SRC_IND = 2'b01,
        SRC_INIT = 2'b10
    } mecc_src_t;
endpackage

// ===== bench/mecc_mem_model.sv
// memory array model behind the controller
`timescale 1ns/10ps
module mecc_mem_model (
    input logic pclk, // clock
    input logic stall, // hold off answers
    input logic mem_req, // request
    input logic mem_we, // write
    input logic [8:0] mem_addr, // word address
    input logic [103:0] mem_wdata, // word in
    output logic mem_ack = 1'b0, // done pulse
    output logic [103:0] mem_rdata = '0 // word out
);
    logic [103:0] ram [512];
    logic go_q = 1'b0;
    // whole words after one wait cycle; data lines invert when idle
    always @(posedge pclk) begin
        go_q <= mem_req && !mem_ack && !go_q && !stall;
        mem_ack <= go_q;
        mem_rdata <= (go_q && !mem_we) ? ram[mem_addr] : ~mem_rdata;
        if (go_q && mem_we) begin
            ram[mem_addr] <= mem_wdata;
        end
    end
endmodule

// ===== bench/mecc_ctrl_monitor.sv
// port assertions for the memory ecc controller
`timescale 1ns/10ps
module mecc_ctrl_monitor (
    input logic pclk, // clock
    input logic presetn, // reset
    input logic psel, // select
    input logic penable, // access
    input logic [7:0] paddr, // address
    input logic pready, // ready
    input logic pslverr, // error
    input logic per_ack, // done
    input logic per_dbe, // double
    input logic mem_req, // request
    input logic mem_ack, // answer
    input logic [8:0] mem_addr, // address
    input logic irq_dbe // irq
);
    logic [12:0] wait_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles an open memory request has waited
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 13'h0;
        end else begin
            wait_q <= (mem_req && !mem_ack) ? wait_q + 13'h1 : 13'h0;
        end
    end
    apb_ready_a: assert property (psel && penable |-> pready) else $error("no ready");
    bad_addr_a: assert property (psel && penable && paddr > 8'h4C |-> pslverr) else $error("no err");
    ack_pulse_a: assert property (per_ack |=> !per_ack) else $error("long ack");
    ack_cause_a: assert property (per_ack |-> $past(mem_ack)) else $error("ack no mem");
    req_hold_a: assert property (mem_req && !mem_ack && wait_q < 13'h7F0 |=> mem_req && $stable(mem_addr))
        else $error("req moved");
    wdog_early_a: assert property ($fell(mem_req) && !$past(mem_ack) |-> $past(wait_q) > 13'h7F8)
        else $error("early drop");
    wdog_late_a: assert property (wait_q < 13'h808) else $error("late drop");
    dbe_irq_a: assert property (per_dbe |-> ##[0:2] irq_dbe) else $error("no irq");
endmodule
bind mecc_ctrl mecc_ctrl_monitor mon_u (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .per_ack,
    .per_dbe, .mem_req, .mem_ack, .mem_addr, .irq_dbe);

// ===== bench/tb_top.sv
// self-checking bench for the memory ecc controller
`timescale 1ns/10ps
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, init_req = 1'b0;
    logic per_req = 1'b0, per_we = 1'b0, stall = 1'b0, pready, pslverr, per_ack, per_sbe, per_dbe, sb, db, er;
    logic mem_req, mem_we, mem_ack, irq_sbe, irq_dbe;
    logic [7:0] paddr = 8'h00, per_be = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [8:0] per_addr = 9'h0, mem_addr;
    logic [63:0] per_wdata = 64'h0, per_rdata, rd;
    logic [103:0] mem_wdata, mem_rdata;
    int fail_count = 0, num_checks = 0, cyc = 0;
    mecc_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .init_req, .per_req, .per_we, .per_be, .per_addr, .per_wdata, .per_ack, .per_rdata, .per_sbe, .per_dbe,
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .irq_sbe, .irq_dbe);
    mecc_mem_model mem_u (.pclk, .stall, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    // clock and hang guard
    initial begin
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [103:0] got, input logic [103:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {r, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic per(input logic w, input logic [7:0] be, input logic [8:0] a, input logic [63:0] d);
        @(posedge pclk) {per_req, per_we, per_be, per_addr, per_wdata} <= {1'b1, w, be, a, d};
        do @(posedge pclk); while (per_ack !== 1'b1);
        {rd, sb, db} = {per_rdata, per_sbe, per_dbe};
        per_req <= 1'b0;
    endtask
    task automatic poll(input int b, input logic v);
        do apb(1'b0, 8'h04, 32'h0); while (r[b] !== v);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // clear from reset control, wait for done
        @(posedge pclk) init_req <= 1'b1;
        @(posedge pclk) init_req <= 1'b0;
        poll(mecc_pkg::STAT_INIT_DONE, 1'b1);
        chk(mem_u.ram[mecc_pkg::LAST_ADDR], 104'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h0);
        per(1'b1, 8'hFF, 9'h5, 64'h0123456789ABCDEF);
        chk(mem_u.ram[5], {40'h0, 64'h0123456789ABCDEF});
        mem_u.ram[5][103] = 1'b1;
        per(1'b0, 8'hFF, 9'h5, 64'h0);
        chk({rd, sb, db}, {64'h0123456789ABCDEF, 2'b00});
        apb(1'b1, 8'h00, 32'h5);
        per(1'b1, 8'hFF, 9'h7, 64'hA5A5A5A5A5A5A5A5);
        mem_u.ram[7][3] = ~mem_u.ram[7][3];
        per(1'b0, 8'hFF, 9'h7, 64'h0);
        chk({rd, sb, db}, {64'hA5A5A5A5A5A5A5A5, 2'b10});
        apb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk(r, 32'h7);
        apb(1'b0, 8'h40, 32'h0);
        chk(r, 32'h7);
        // byte write merges into corrected word
        per(1'b1, 8'h02, 9'h7, 64'h3C00);
        per(1'b0, 8'hFF, 9'h7, 64'h0);
        chk({rd, sb}, {64'hA5A5A5A5A5A53CA5, 1'b0});
        mem_u.ram[7][1:0] = ~mem_u.ram[7][1:0];
        per(1'b0, 8'hFF, 9'h7, 64'h0);
        chk(db, 1'b1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r, 32'h7);
        apb(1'b1, 8'h14, 32'h9);
        apb(1'b1, 8'h20, 32'h89ABCDEF);
        apb(1'b1, 8'h24, 32'h01234567);
        apb(1'b1, 8'h28, 32'hFFFFFFFF);
        apb(1'b1, 8'h2C, 32'h0);
        apb(1'b1, 8'h18, 32'h7);
        apb(1'b1, 8'h1C, 32'h1);
        poll(mecc_pkg::STAT_ACC_BUSY, 1'b0);
        chk(mem_u.ram[9], {20'h0, 20'hFFFFF, 64'h0123456789ABCDEF});
        stall <= 1'b1;
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h1C, 32'h1);
        poll(mecc_pkg::STAT_TMO, 1'b1);
        chk(r[mecc_pkg::STAT_ACC_BUSY], 1'b0);
        stall <= 1'b0;
        apb(1'b1, 8'h04, 32'h2C);
        @(negedge pclk) chk({irq_sbe, irq_dbe}, 2'b00);
        apb(1'b1, 8'h00, 32'h301);
        @(negedge pclk) chk({irq_sbe, irq_dbe}, 2'b11);
        apb(1'b0, 8'h80, 32'h0);
        chk({er, r}, {1'b1, 32'h0});
        test_done();
    end
endmodule
